// File: trfd_pkg.sv
// Purpose: constants and types for the configuration frame decoder
// Assumes: 4KB pages, 16 pages per half, 8 context banks
// Notes  : all offsets are bytes from the base of their page
//
// Overview of operation
// - frame splits into global then bank halves
// - all state grouped in page-aligned pages
// - page size 4KB or 64KB, reported read-only
// - pages per half is two to index+1
// - each half is page count times page size
// - bank n starts n pages into bank half
// - global pages 0-3: space0, space1, impl, perf
// - global page 4 determination space, Secure only
// - page 5 continuation, pages 6+ impl space
// - both states reach global half, some Secure-only
// - banked copies by security, Secure aliases exist
// - restrict bit: global except impl space, stage-2 banks Secure-only
// - restrict never relaxes existing Secure-only ranges
// - bank 0 first page, one page each
// - implemented bank count reported read-only
// - above implemented banks reads zero, writes ignored
// - stage-2-only bank count reported read-only
// - 32-bit atomic access to global space 0
package trfd_pkg;
  localparam int unsigned PAGE_SHIFT       = 12;
  localparam logic        PAGE_BYTES_CODE  = 1'h0; // 0: 4KB, 1: 64KB
  localparam logic [2:0]  PAGE_COUNT_INDEX = 3'h3;
  localparam int unsigned PAGE_IDX_W       = int'(PAGE_COUNT_INDEX) + 1;
  localparam int unsigned REGION_BIT       = PAGE_SHIFT + PAGE_IDX_W;
  localparam int unsigned FRAME_AW         = REGION_BIT + 1;
  localparam logic [7:0]  BANK_COUNT       = 8'h08;
  localparam logic [7:0]  S2_BANK_COUNT    = 8'h02;
  localparam int unsigned BANK_IDX_W       = 3;
  localparam int unsigned ARCH_VERSION     = 2;

  localparam logic [3:0] PG_SPACE0 = 4'h0;
  localparam logic [3:0] PG_SPACE1 = 4'h1;
  localparam logic [3:0] PG_IMPL   = 4'h2;
  localparam logic [3:0] PG_PERF   = 4'h3;
  localparam logic [3:0] PG_DET    = 4'h4;
  localparam logic [3:0] PG_CONT   = 4'h5;

  localparam logic [11:0] OFS_CONTROL    = 12'h000;
  localparam logic [11:0] OFS_SECCFG1    = 12'h004;
  localparam logic [11:0] OFS_IDENT1     = 12'h024;
  localparam logic [11:0] OFS_DENIED     = 12'h048;
  localparam logic [11:0] OFS_NS_CONTROL = 12'h400;
  localparam logic [11:0] OFS_DET_WORD   = 12'h000;
  localparam logic [11:0] OFS_BANK_WORD  = 12'h000;

  localparam int unsigned ID_PAGE_BYTES_BIT = 31;
  localparam int unsigned ID_PAGE_INDEX_LSB = 28;
  localparam int unsigned ID_S2_BANKS_LSB   = 16;
  localparam int unsigned ID_BANKS_LSB      = 0;
  localparam logic [31:0] IDENT1_VALUE =
    (32'(PAGE_BYTES_CODE) << ID_PAGE_BYTES_BIT) |
    (32'(PAGE_COUNT_INDEX) << ID_PAGE_INDEX_LSB) |
    (32'(S2_BANK_COUNT) << ID_S2_BANKS_LSB) |
    (32'(BANK_COUNT) << ID_BANKS_LSB);

  localparam int unsigned SC1_RESTRICT_BIT = 0;
  localparam logic [31:0] WORD_RST         = 32'h0000_0000;
  localparam logic [15:0] COUNT_RST        = 16'h0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    SP_SPACE0, SP_SPACE1, SP_IMPL, SP_PERF,
    SP_DET, SP_CONT, SP_BANK, SP_VOID
  } trfd_space_t;
endpackage : trfd_pkg

// File: trfd_dec_if.sv
// Purpose: carries one frame offset to the page decoder and back
// Assumes: purely combinational decode
// Notes  : one instance per bus direction
`timescale 1ns/1ps
interface trfd_dec_if;
  logic [trfd_pkg::FRAME_AW-1:0]   offset;
  logic                            nonSecure;
  logic                            restrictOn;
  trfd_pkg::trfd_space_t           space;
  logic [trfd_pkg::PAGE_IDX_W-1:0] page;
  logic                            deny;
  modport requester (output offset, nonSecure, restrictOn,
                     input space, page, deny);
  modport decoder (input offset, nonSecure, restrictOn,
                   output space, page, deny);
endinterface : trfd_dec_if

// File: trfd_page_decode.sv
// Purpose: maps a frame offset to its address space and access verdict
// Assumes: offset already known to lie inside the frame
// Notes  : implementation space stays open under restricted mode
`timescale 1ns/1ps
module trfd_page_decode (
  trfd_dec_if.decoder dec
);
  logic bankHalf;
  logic stage2Bank;
  logic detOnly;
  logic restricted;

  assign bankHalf = dec.offset[trfd_pkg::REGION_BIT];
  assign dec.page =
    dec.offset[trfd_pkg::REGION_BIT-1:trfd_pkg::PAGE_SHIFT];
  assign stage2Bank = bankHalf &&
    ({4'h0, dec.page} < trfd_pkg::S2_BANK_COUNT);

  always_comb begin
    if (bankHalf) begin
      dec.space = ({4'h0, dec.page} < trfd_pkg::BANK_COUNT) ?
                  trfd_pkg::SP_BANK : trfd_pkg::SP_VOID;
    end else begin
      unique case (dec.page)
        trfd_pkg::PG_SPACE0: dec.space = trfd_pkg::SP_SPACE0;
        trfd_pkg::PG_SPACE1: dec.space = trfd_pkg::SP_SPACE1;
        trfd_pkg::PG_IMPL:   dec.space = trfd_pkg::SP_IMPL;
        trfd_pkg::PG_PERF:   dec.space = trfd_pkg::SP_PERF;
        trfd_pkg::PG_DET:    dec.space = trfd_pkg::SP_DET;
        trfd_pkg::PG_CONT:   dec.space = (trfd_pkg::ARCH_VERSION == 2) ?
          trfd_pkg::SP_CONT : trfd_pkg::SP_VOID;
        default:             dec.space = trfd_pkg::SP_IMPL;
      endcase
    end
  end

  // restriction is or-ed on top, so it can only add refusals
  assign detOnly = !bankHalf && (dec.page == trfd_pkg::PG_DET);
  assign restricted = dec.restrictOn &&
    (bankHalf ? stage2Bank : (dec.space != trfd_pkg::SP_IMPL));
  assign dec.deny = dec.nonSecure && (detOnly || restricted);
endmodule : trfd_page_decode

// File: trfd_frame_regs.sv
// Purpose: AXI4-Lite slave for the configuration frame and its pages
// Assumes: prot bit 1 high marks a Non-secure access
// Notes  : refused access answers SLVERR, beyond the frame DECERR
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module trfd_frame_regs (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        awvalid,
  output wire logic        awready,
  input  wire logic [31:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        wvalid,
  output wire logic        wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output wire logic        bvalid,
  input  wire logic        bready,
  output wire logic [1:0]  bresp,
  input  wire logic        arvalid,
  output wire logic        arready,
  input  wire logic [31:0] araddr,
  input  wire logic [2:0]  arprot,
  output wire logic        rvalid,
  input  wire logic        rready,
  output wire logic [31:0] rdata,
  output wire logic [1:0]  rresp,
  output wire logic        restrictActive
);
  localparam int unsigned NB  = int'(trfd_pkg::BANK_COUNT);
  localparam int unsigned BIW = trfd_pkg::BANK_IDX_W;
  localparam int unsigned FAW = trfd_pkg::FRAME_AW;
  localparam int unsigned PS  = trfd_pkg::PAGE_SHIFT;

  logic              awHeld_ff;
  logic [31:0]       awAddr_ff;
  logic              awNs_ff;
  logic              wHeld_ff;
  logic [31:0]       wData_ff;
  logic [3:0]        wStrb_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;
  logic [31:0]       ctrlSec_ff;
  logic [31:0]       ctrlNs_ff;
  logic [31:0]       secCfg1_ff;
  logic [31:0]       detWord_ff;
  logic [31:0]       bankWord_ff [NB];
  logic [15:0]       deniedCnt_ff;
  logic              doWrite;
  logic              rdTake;
  logic              wrOutside;
  logic              rdOutside;
  logic              wrFault;
  logic              rdFault;
  logic              wrOk;
  logic              wrSpace0;
  logic              wrCtrlSec;
  logic              wrCtrlNs;
  logic              wrSecCfg1;
  logic              wrDet;
  logic              wrBank;
  logic [BIW-1:0]    wrBankIdx;
  logic [11:0]       wrOfs;
  logic [11:0]       rdOfs;
  logic              arNs;
  logic [31:0]       rdBankWord;
  logic [1:0]        nxt_bresp;
  logic [1:0]        nxt_rresp;
  logic [31:0]       nxt_rdata;

  trfd_dec_if wrDec ();
  trfd_dec_if rdDec ();

  trfd_page_decode uWrDec (
    .dec (wrDec)
  );

  trfd_page_decode uRdDec (
    .dec (rdDec)
  );

  function automatic logic secOnlyReg(input trfd_pkg::trfd_space_t sp,
                                      input logic [11:0]          ofs);
    secOnlyReg = (sp == trfd_pkg::SP_SPACE0) &&
                 ((ofs == trfd_pkg::OFS_SECCFG1) ||
                  (ofs == trfd_pkg::OFS_NS_CONTROL));
  endfunction : secOnlyReg

  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] dat,
                                             input logic [3:0]  strb);
    for (int i = 0; i < 4; i++) begin
      mergeBytes[8*i +: 8] = strb[i] ? dat[8*i +: 8] : old[8*i +: 8];
    end
  endfunction : mergeBytes

  // handshakes drop while ce is low so nothing is taken in a freeze
  assign awready = ce && !awHeld_ff && !bvalid_ff;
  assign wready  = ce && !wHeld_ff && !bvalid_ff;
  assign arready = ce && !rvalid_ff;
  assign bvalid  = ce && bvalid_ff;
  assign rvalid  = ce && rvalid_ff;
  assign bresp   = bresp_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;
  assign restrictActive = secCfg1_ff[trfd_pkg::SC1_RESTRICT_BIT];

  assign doWrite = ce && awHeld_ff && wHeld_ff && !bvalid_ff;
  assign rdTake  = arvalid && arready;

  // write side decode
  assign wrDec.offset     = awAddr_ff[FAW-1:0];
  assign wrDec.nonSecure  = awNs_ff;
  assign wrDec.restrictOn = restrictActive;
  assign wrOutside = |awAddr_ff[31:FAW];
  assign wrOfs     = awAddr_ff[PS-1:0];
  assign wrFault   = wrDec.deny ||
                     (awNs_ff && secOnlyReg(wrDec.space, wrOfs));
  assign wrOk      = doWrite && !wrOutside && !wrFault;
  assign wrSpace0  = wrOk && (wrDec.space == trfd_pkg::SP_SPACE0);
  assign wrCtrlSec = wrSpace0 && !awNs_ff &&
                     (wrOfs == trfd_pkg::OFS_CONTROL);
  assign wrCtrlNs  = wrSpace0 &&
                     ((awNs_ff && (wrOfs == trfd_pkg::OFS_CONTROL)) ||
                      (wrOfs == trfd_pkg::OFS_NS_CONTROL));
  assign wrSecCfg1 = wrSpace0 && (wrOfs == trfd_pkg::OFS_SECCFG1);
  assign wrDet     = wrOk && (wrDec.space == trfd_pkg::SP_DET) &&
                     (wrOfs == trfd_pkg::OFS_DET_WORD);
  // pages above the last bank decode as SP_VOID and store nothing
  assign wrBank    = wrOk && (wrDec.space == trfd_pkg::SP_BANK) &&
                     (wrOfs == trfd_pkg::OFS_BANK_WORD);
  assign wrBankIdx = awAddr_ff[PS +: BIW];
  assign nxt_bresp = wrOutside ? trfd_pkg::RESP_DECERR :
                     wrFault ? trfd_pkg::RESP_SLVERR : trfd_pkg::RESP_OKAY;

  // read side decode straight off the address channel
  assign rdDec.offset     = araddr[FAW-1:0];
  assign rdDec.nonSecure  = arNs;
  assign rdDec.restrictOn = restrictActive;
  assign arNs       = arprot[1];
  assign rdOutside  = |araddr[31:FAW];
  assign rdOfs      = araddr[PS-1:0];
  assign rdFault    = rdDec.deny || (arNs && secOnlyReg(rdDec.space, rdOfs));
  assign rdBankWord = bankWord_ff[araddr[PS +: BIW]];

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_rresp = trfd_pkg::RESP_OKAY;
    if (rdOutside) begin
      nxt_rresp = trfd_pkg::RESP_DECERR;
    end else if (rdFault) begin
      nxt_rresp = trfd_pkg::RESP_SLVERR;
    end else begin
      case (rdDec.space)
        trfd_pkg::SP_SPACE0: begin
          if (rdOfs == trfd_pkg::OFS_CONTROL) begin
            nxt_rdata = arNs ? ctrlNs_ff : ctrlSec_ff;
          end else if (rdOfs == trfd_pkg::OFS_NS_CONTROL) begin
            nxt_rdata = ctrlNs_ff;
          end else if (rdOfs == trfd_pkg::OFS_SECCFG1) begin
            nxt_rdata = secCfg1_ff;
          end else if (rdOfs == trfd_pkg::OFS_IDENT1) begin
            nxt_rdata = trfd_pkg::IDENT1_VALUE;
          end else if (rdOfs == trfd_pkg::OFS_DENIED) begin
            nxt_rdata = {16'h0000, deniedCnt_ff};
          end
        end
        trfd_pkg::SP_DET: begin
          if (rdOfs == trfd_pkg::OFS_DET_WORD) begin
            nxt_rdata = detWord_ff;
          end
        end
        trfd_pkg::SP_BANK: begin
          if (rdOfs == trfd_pkg::OFS_BANK_WORD) begin
            nxt_rdata = rdBankWord;
          end
        end
        // other spaces hold no state here and read as zero
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // write address channel
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      awHeld_ff <= 1'h0;
      awAddr_ff <= 32'h0000_0000;
      awNs_ff   <= 1'h0;
    end else if (ce) begin
      if (awvalid && awready) begin
        awHeld_ff <= 1'h1;
        awAddr_ff <= awaddr;
        awNs_ff   <= awprot[1];
      end else if (doWrite) begin
        awHeld_ff <= 1'h0;
      end
    end
  end

  // write data channel
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wHeld_ff <= 1'h0;
      wData_ff <= 32'h0000_0000;
      wStrb_ff <= 4'h0;
    end else if (ce) begin
      if (wvalid && wready) begin
        wHeld_ff <= 1'h1;
        wData_ff <= wdata;
        wStrb_ff <= wstrb;
      end else if (doWrite) begin
        wHeld_ff <= 1'h0;
      end
    end
  end

  // write response
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bvalid_ff <= 1'h0;
      bresp_ff  <= trfd_pkg::RESP_OKAY;
    end else if (ce) begin
      if (doWrite) begin
        bvalid_ff <= 1'h1;
        bresp_ff  <= nxt_bresp;
      end else if (bready) begin
        bvalid_ff <= 1'h0;
      end
    end
  end

  // read response, one word per access keeps 32-bit reads atomic
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rvalid_ff <= 1'h0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= trfd_pkg::RESP_OKAY;
    end else if (ce) begin
      if (rdTake) begin
        rvalid_ff <= 1'h1;
        rdata_ff  <= nxt_rdata;
        rresp_ff  <= nxt_rresp;
      end else if (rready) begin
        rvalid_ff <= 1'h0;
      end
    end
  end

  // banked control copies and the Secure configuration word
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrlSec_ff <= trfd_pkg::WORD_RST;
      ctrlNs_ff  <= trfd_pkg::WORD_RST;
      secCfg1_ff <= trfd_pkg::WORD_RST;
    end else if (ce) begin
      if (wrCtrlSec) begin
        ctrlSec_ff <= mergeBytes(ctrlSec_ff, wData_ff, wStrb_ff);
      end
      if (wrCtrlNs) begin
        ctrlNs_ff <= mergeBytes(ctrlNs_ff, wData_ff, wStrb_ff);
      end
      if (wrSecCfg1) begin
        secCfg1_ff <= mergeBytes(secCfg1_ff, wData_ff, wStrb_ff);
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      detWord_ff <= trfd_pkg::WORD_RST;
    end else if (ce && wrDet) begin
      detWord_ff <= mergeBytes(detWord_ff, wData_ff, wStrb_ff);
    end
  end

  for (genvar b = 0; b < NB; b++) begin : g_bank
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        bankWord_ff[b] <= trfd_pkg::WORD_RST;
      end else if (ce && wrBank && (wrBankIdx == BIW'(b))) begin
        bankWord_ff[b] <= mergeBytes(bankWord_ff[b], wData_ff, wStrb_ff);
      end
    end
  end

  // refused accesses counted so software can spot probing; wraps
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      deniedCnt_ff <= trfd_pkg::COUNT_RST;
    end else if (ce) begin
      deniedCnt_ff <= deniedCnt_ff +
        16'(doWrite && !wrOutside && wrFault) +
        16'(rdTake && !rdOutside && rdFault);
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  sequence wrBothTaken;
    awvalid && awready && wvalid && wready;
  endsequence

  sequence wrTwoLiveEdges;
    ce ##1 ce;
  endsequence

  sequence rdGlobal(logic [3:0] pg);
    rdTake && !rdOutside && !araddr[trfd_pkg::REGION_BIT] &&
    (rdDec.page == pg);
  endsequence

  void_read_a: assert property (
    rdTake && !rdOutside && araddr[trfd_pkg::REGION_BIT] &&
    ({4'h0, rdDec.page} >= trfd_pkg::BANK_COUNT)
    |=> rdata == 32'h0000_0000 && rresp == trfd_pkg::RESP_OKAY)
    else $error("unimplemented bank page did not read zero");

  cont_read_a: assert property (
    rdGlobal(trfd_pkg::PG_CONT) and (!arNs && rdOfs == 12'h000)
    |=> rdata == 32'h0000_0000 && rresp == trfd_pkg::RESP_OKAY)
    else $error("continuation page read not zero");

  det_secure_a: assert property (
    rdGlobal(trfd_pkg::PG_DET) and arNs
    |=> rresp == trfd_pkg::RESP_SLVERR)
    else $error("Non-secure access reached determination page");

  restrict_global_a: assert property (
    rdGlobal(trfd_pkg::PG_SPACE1) and (arNs && restrictActive)
    |=> rresp == trfd_pkg::RESP_SLVERR)
    else $error("restricted mode let Non-secure read through");

  secure_kept_a: assert property (
    rdGlobal(trfd_pkg::PG_SPACE0) and
    (arNs && rdOfs == trfd_pkg::OFS_SECCFG1)
    |=> rresp == trfd_pkg::RESP_SLVERR)
    else $error("Secure-only word open to Non-secure access");

  ns_global_a: assert property (
    rdGlobal(trfd_pkg::PG_SPACE0) and
    (arNs && !restrictActive && rdOfs == trfd_pkg::OFS_CONTROL)
    |=> rresp == trfd_pkg::RESP_OKAY)
    else $error("Non-secure read of global space refused");

  ident_value_a: assert property (
    rdGlobal(trfd_pkg::PG_SPACE0) and
    (!arNs && rdOfs == trfd_pkg::OFS_IDENT1)
    |=> rdata == trfd_pkg::IDENT1_VALUE)
    else $error("identification word wrong");

  banked_select_a: assert property (
    rdGlobal(trfd_pkg::PG_SPACE0) and
    (rdOfs == trfd_pkg::OFS_CONTROL && (!arNs || !restrictActive))
    |=> rdata == ($past(arNs) ? $past(ctrlNs_ff) : $past(ctrlSec_ff)))
    else $error("banked copy chosen by wrong security state");

  bank_read_a: assert property (
    rdTake && !rdOutside && !arNs && araddr[trfd_pkg::REGION_BIT] &&
    ({4'h0, rdDec.page} < trfd_pkg::BANK_COUNT) && rdOfs == 12'h000
    |=> rdata == $past(rdBankWord))
    else $error("bank page returned wrong bank word");

  wr_complete_a: assert property (
    wrBothTaken ##1 wrTwoLiveEdges |-> bvalid)
    else $error("write not answered two cycles after it was taken");

  wr_outside_a: assert property (
    (wrBothTaken and |awaddr[31:FAW]) ##1 wrTwoLiveEdges
    |-> bvalid && bresp == trfd_pkg::RESP_DECERR)
    else $error("write beyond frame top not decode error");
endmodule : trfd_frame_regs

// File: trfd_cpu_model.sv
// Purpose: processor side issuing configuration accesses
// Assumes: AXI4-Lite, prot bit 1 high marks a Non-secure access
// Notes  : waits for every answer, only the bench timeout cuts a hang
`timescale 1ns/1ps
module trfd_cpu_model (
  input  wire logic        mclk,
  output logic             awvalid,
  input  wire logic        awready,
  output logic      [31:0] awaddr,
  output logic      [2:0]  awprot,
  output logic             wvalid,
  input  wire logic        wready,
  output logic      [31:0] wdata,
  output logic      [3:0]  wstrb,
  input  wire logic        bvalid,
  output logic             bready,
  input  wire logic [1:0]  bresp,
  output logic             arvalid,
  input  wire logic        arready,
  output logic      [31:0] araddr,
  output logic      [2:0]  arprot,
  input  wire logic        rvalid,
  output logic             rready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp
);
  // cycles to wait before taking read data, to test a slow processor
  int lag = 0;

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, wdata, araddr} = 96'h0;
    {awprot, arprot} = 6'h00;
    wstrb = 4'hF;
  end

  // offsets are from a base aligned to the whole frame
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic ns, output logic [1:0] r);
    @(posedge mclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    awprot  <= {1'b0, ns, 1'b0};
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    fork
      begin
        do @(posedge mclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        // released address and data lines show the inverse; prot and strobes keep their values
        awaddr  <= ~a;
      end
      begin
        do @(posedge mclk); while (wready !== 1'b1);
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
    join
    while (bvalid !== 1'b1) @(posedge mclk);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic ns,
                    output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    arvalid <= 1'b1;
    araddr  <= a;
    arprot  <= {1'b0, ns, 1'b0};
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    araddr  <= ~a;
    repeat (lag) @(posedge mclk);
    rready <= 1'b1;
    do @(posedge mclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
endmodule : trfd_cpu_model

// File: tb_top.sv
// Purpose: self-checking bench for the configuration frame decoder
// Assumes: frame base at 0, sizes follow the package constants
// Notes  : every address is a frame offset
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module tb_top;
  localparam logic [31:0] PGB = trfd_pkg::PAGE_BYTES_CODE ? 32'h10000
                                                           : 32'h1000;
  localparam int unsigned NPG = 2 ** (int'(trfd_pkg::PAGE_COUNT_INDEX) + 1);
  localparam logic [31:0] HALF = 32'(NPG) * PGB;
  localparam logic [1:0]  OK = trfd_pkg::RESP_OKAY;
  localparam logic [1:0]  SE = trfd_pkg::RESP_SLVERR;
  localparam logic        S = 1'b0;
  localparam logic        NS = 1'b1;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        ce = 1'b1;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, restrictActive;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [2:0]  awprot, arprot;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          err_total = 0;
  int          checked = 0;
  int          cyc = 0;

  always #10 mclk = ~mclk;

  trfd_frame_regs i_dut (.mclk, .nrst, .ce, .awvalid, .awready, .awaddr,
    .awprot, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .arprot, .rvalid, .rready, .rdata,
    .rresp, .restrictActive);

  trfd_cpu_model i_cpu (.mclk, .awvalid, .awready, .awaddr, .awprot,
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .arprot, .rvalid, .rready, .rdata, .rresp);

  task automatic rdc(input logic [31:0] a, input logic ns,
                     input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    i_cpu.rd(a, ns, d, r);
    `CHK(r, er)
    `CHK(d, ed)
  endtask : rdc

  task automatic wrc(input logic [31:0] a, input logic [31:0] v,
                     input logic ns, input logic [1:0] er);
    logic [1:0] r;
    i_cpu.wr(a, v, ns, r);
    `CHK(r, er)
  endtask : wrc

  task automatic t_ident();
    `CHK(restrictActive, 1'b0)
    rdc(32'h24, S, {trfd_pkg::PAGE_BYTES_CODE, trfd_pkg::PAGE_COUNT_INDEX,
        4'h0, trfd_pkg::S2_BANK_COUNT, 8'h00, trfd_pkg::BANK_COUNT},
        OK);
    $display("test ident done");
  endtask : t_ident

  task automatic t_pages();
    for (int p = 0; p < NPG; p++) begin
      rdc(32'(p) * PGB + 32'h8, NS, 32'h0,
          (p == 4) ? SE : OK);
    end
    rdc(4 * PGB + 32'h8, S, 32'h0, OK);
    rdc(5 * PGB, S, 32'h0, OK);
    $display("test pages done");
  endtask : t_pages

  task automatic t_secure();
    wrc(4 * PGB, 32'h5A5A_A5A5, S, OK);
    wrc(4 * PGB, 32'h0000_0001, NS, SE);
    rdc(4 * PGB, S, 32'h5A5A_A5A5, OK);
    wrc(32'h4, 32'h1, NS, SE);
    rdc(32'h4, S, 32'h0, OK);
    rdc(32'h4, NS, 32'h0, SE);
    `CHK(restrictActive, 1'b0)
    $display("test secure done");
  endtask : t_secure

  task automatic t_banked();
    wrc(32'h0, 32'h1111_1111, S, OK);
    wrc(32'h0, 32'h2222_2222, NS, OK);
    rdc(32'h0, S, 32'h1111_1111, OK);
    rdc(32'h0, NS, 32'h2222_2222, OK);
    rdc(32'h400, S, 32'h2222_2222, OK);
    wrc(32'h400, 32'h0, NS, SE);
    wrc(32'h400, 32'h3333_3333, S, OK);
    rdc(32'h0, NS, 32'h3333_3333, OK);
    rdc(32'h0, S, 32'h1111_1111, OK);
    $display("test banked done");
  endtask : t_banked

  task automatic t_banks();
    logic [31:0] d;
    logic [1:0]  r;
    for (int n = 0; n < NPG; n++) begin
      wrc(HALF + 32'(n) * PGB, 32'hB0 + 32'(n), NS, OK);
    end
    i_cpu.lag = 3;
    for (int n = 0; n < NPG; n++) begin
      rdc(HALF + 32'(n) * PGB, NS, (n < int'(trfd_pkg::BANK_COUNT)) ?
          32'hB0 + 32'(n) : 32'h0, OK);
    end
    i_cpu.lag = 0;
    rdc(HALF + PGB, S, 32'hB1, OK);
    rdc(2 * HALF - 32'h4, S, 32'h0, OK);
    i_cpu.rd(2 * HALF, S, d, r);
    `CHK(r, trfd_pkg::RESP_DECERR)
    wrc(2 * HALF, 32'h1, S, trfd_pkg::RESP_DECERR);
    $display("test banks done");
  endtask : t_banks

  task automatic t_restrict();
    logic [1:0] e;
    wrc(32'h4, 32'h1, S, OK);
    `CHK(restrictActive, 1'b1)
    for (int p = 0; p < NPG; p++) begin
      // implementation pages stay open, a cheaper and allowed reading
      e = (p == 2 || p >= 6) ? OK : SE;
      rdc(32'(p) * PGB + 32'h8, NS, 32'h0, e);
      rdc(32'(p) * PGB + 32'h8, S, 32'h0, OK);
    end
    for (int n = 0; n < 4; n++) begin
      e = (n < int'(trfd_pkg::S2_BANK_COUNT)) ? SE : OK;
      rdc(HALF + 32'(n) * PGB, NS, (e == OK) ? 32'hB0 + 32'(n) : 32'h0,
          e);
    end
    wrc(32'h4, 32'h0, S, OK);
    `CHK(restrictActive, 1'b0)
    rdc(32'h8, NS, 32'h0, OK);
    // a frozen block must take nothing, so no access is split
    ce <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK({awready, wready, arready, bvalid, rvalid}, 5'h00)
    ce <= 1'b1;
    $display("test restrict done");
  endtask : t_restrict

  task automatic give_verdict();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      $display("BAD %0t timeout", $time);
      give_verdict();
    end
  end

  initial begin
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    t_ident();
    t_pages();
    t_secure();
    t_banked();
    t_banks();
    t_restrict();
    give_verdict();
  end
endmodule : tb_top
